// ---- hdl/atapp_port.sv ----
// Purpose: host-port handshake outputs and protect/power-down pin handling
// Assumes: host inputs synchronous to clk; resetN and porN are active-low levels
// Notes:   pin function is held in a retained cell that no reset clears
//
// Functional notes
// - ready-to-transfer output is always asserted, never stretches a cycle
// - device readiness output negates to pause an incoming Ultra DMA burst
// - read strobe toggles once per word, both edges carry data
// - read burst pauses by holding the strobe when no word is available
// - word-width output is driven low for every 16-bit data cycle
// - interrupt request output is active high
// - host reset input is active low
// - pin acts as exactly one function, protect or power-down
// - function chosen by pin-function command; protect after first power-up
// - chosen function survives power cycles and resets
// - with protect active and pin low, destructive commands are refused
// - refused command reports status 51H and error 04H
// - non-destructive commands still run normally under protect
// - power-down pin during a command: finish, then enter standby
// - in pin-forced standby no further commands are accepted
// - only srst, or a power-on or hardware reset with pin high, leaves standby
// - first power-up reports busy for about five seconds
module atapp_port #(
  parameter int unsigned INIT_CYC  = atapp_pkg::INIT_BUSY_CYC,
  parameter int unsigned CMD_CYC   = atapp_pkg::CMD_EXEC_CYC,
  parameter int unsigned WIDTH     = atapp_pkg::WORD_W,
  parameter int unsigned DEPTH     = atapp_pkg::FIFO_DEPTH
) (
  // clock and resets
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic                      resetN,
  input  wire logic                      porN,
  // protect/power-down pin, active low
  input  wire logic                      protect_powerdown_pinN,
  // command from task-file decode
  input  wire logic                      cmdValid,
  input  wire atapp_pkg::atapp_cmd_t     cmdIn,
  output logic                           cmdAccept,
  output atapp_pkg::atapp_rpt_t          rpt,
  output logic                           rptValid,
  // status toward host
  output logic                           busy,
  output logic                           standby,
  output logic                           pinFunc,
  output logic                           iordy,
  output logic                           iocs16N,
  output logic                           intrq,
  input  wire logic                      intAck,
  // ultra dma write (host to device)
  input  wire logic                      udmaWrActive,
  input  wire logic                      hostWordValid,
  input  wire logic [WIDTH-1:0]          hostWord,
  output logic                           ddmardyN,
  output logic                           mediaWordValid,
  output logic      [WIDTH-1:0]          mediaWord,
  input  wire logic                      mediaReady,
  // ultra dma read (device to host)
  input  wire logic                      udmaRdActive,
  input  wire logic                      hdmardyN,
  input  wire logic                      rdWordValid,
  input  wire logic [WIDTH-1:0]          rdWord,
  output logic                           rdWordReady,
  output logic                           dstrobe,
  output logic      [WIDTH-1:0]          dataOut,
  // retained configuration cell (non-volatile in silicon)
  input  wire logic                      nvFirstBoot,
  input  wire logic                      nvFunc,
  output logic                           nvWrite,
  output logic                           nvWrData
);

  typedef enum logic [2:0] {IDLE, INIT, EXEC, DONE, SLEEP} atapp_state_t;

  function automatic logic is_destructive(input logic [7:0] op);
    return (op == atapp_pkg::CMD_ERASE_SECTOR) || (op == atapp_pkg::CMD_FORMAT_TRACK) ||
           (op == atapp_pkg::CMD_WRITE_DMA)    || (op == atapp_pkg::CMD_WRITE_DMA_NR) ||
           (op == atapp_pkg::CMD_WRITE_LONG)   || (op == atapp_pkg::CMD_WRITE_LONG_N) ||
           (op == atapp_pkg::CMD_WRITE_MULT)   || (op == atapp_pkg::CMD_WRITE_MULT_E) ||
           (op == atapp_pkg::CMD_WRITE_SECT)   || (op == atapp_pkg::CMD_WRITE_SECT_N) ||
           (op == atapp_pkg::CMD_WRITE_SECT_E) || (op == atapp_pkg::CMD_WRITE_VERIFY);
  endfunction

  localparam int unsigned CW = $clog2(INIT_CYC + CMD_CYC + 1);

  atapp_state_t          state_r;
  logic [CW-1:0]         cnt_r;
  logic                  pinAtCmd_r;
  logic                  pdSeen_r;
  logic                  sleepHold_r;
  logic [7:0]            op_r;
  logic [7:0]            feat_r;
  logic                  anyRst;
  logic                  take;
  logic                  fifoInReady;
  logic                  ddmardyN_r;
  logic                  dstrobe_r;
  logic [WIDTH-1:0]      dataOut_r;
  logic                  rdTake;

  assign anyRst = srst || !resetN || !porN;
  assign take   = (state_r == IDLE) && cmdValid;

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing

  always_ff @(posedge clk) begin
    if (anyRst) begin
      state_r <= INIT;
      cnt_r   <= '0;
    end else begin
      case (state_r)
        INIT: begin
          // first boot waits the full init time; later boots leave at once
          if (sleepHold_r) begin
            state_r <= SLEEP;
          end else if (!nvFirstBoot || cnt_r >= CW'(INIT_CYC - 1)) begin
            state_r <= IDLE;
            cnt_r   <= '0;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        IDLE: begin
          if (cmdValid) begin
            state_r <= EXEC;
            cnt_r   <= '0;
          end
        end
        EXEC: begin
          if (cnt_r >= CW'(CMD_CYC - 1)) begin
            state_r <= DONE;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        DONE: begin
          // finish the command, then drop to standby if the pin was seen and the power-down function is selected
          if (pdSeen_r && nvFunc == atapp_pkg::ATAPP_FN_PWRDN) begin
            state_r <= SLEEP;
          end else begin
            state_r <= IDLE;
          end
        end
        SLEEP: state_r <= SLEEP;
        default: state_r <= IDLE;
      endcase
    end
  end

  // pin is latched at take so a pin edge mid-command cannot change the verdict
  always_ff @(posedge clk) begin
    if (anyRst) begin
      pinAtCmd_r <= 1'b1;
      op_r       <= '0;
      feat_r     <= '0;
    end else if (take) begin
      pinAtCmd_r <= protect_powerdown_pinN;
      op_r       <= cmdIn.opcode;
      feat_r     <= cmdIn.feature;
    end
  end

  // pin low at take or in any execute cycle arms standby; the command still completes
  always_ff @(posedge clk) begin
    if (anyRst) begin
      pdSeen_r <= 1'b0;
    end else if (take) begin
      pdSeen_r <= !protect_powerdown_pinN;
    end else if (state_r == EXEC && !protect_powerdown_pinN) begin
      pdSeen_r <= 1'b1;
    end
  end

  // standby forced by the pin survives a host or power-on reset taken with the pin low
  // srst is the full system reset and always clears it
  always_ff @(posedge clk) begin
    if (srst) begin
      sleepHold_r <= 1'b0;
    end else if (anyRst) begin
      if (protect_powerdown_pinN) begin
        sleepHold_r <= 1'b0;
      end
    end else if (state_r == SLEEP) begin
      sleepHold_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion report, protect check, retained function

  always_ff @(posedge clk) begin
    if (anyRst) begin
      rptValid <= 1'b0;
      rpt      <= '{status: atapp_pkg::BUSY_STATUS, error: atapp_pkg::OK_ERROR};
    end else if (state_r == DONE) begin
      rptValid <= 1'b1;
      if (nvFunc == atapp_pkg::ATAPP_FN_PROTECT && !pinAtCmd_r
          && is_destructive(op_r)) begin
        rpt <= '{status: atapp_pkg::REFUSE_STATUS, error: atapp_pkg::REFUSE_ERROR};
      end else begin
        rpt <= '{status: atapp_pkg::OK_STATUS, error: atapp_pkg::OK_ERROR};
      end
    end else begin
      rptValid <= 1'b0;
      // only the power-up busy code is replaced; a finished report stands until the next one
      if (state_r == IDLE && rpt.status == atapp_pkg::BUSY_STATUS) begin
        rpt.status <= atapp_pkg::OK_STATUS;
      end
    end
  end

  // written only by the select command; no reset touches the stored value
  always_ff @(posedge clk) begin
    if (anyRst) begin
      nvWrite  <= 1'b0;
      nvWrData <= atapp_pkg::ATAPP_FN_PROTECT;
    end else begin
      nvWrite  <= (state_r == DONE) && (op_r == atapp_pkg::CMD_PIN_FUNC);
      nvWrData <= (feat_r == atapp_pkg::PIN_FUNC_PWRDN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host-facing status lines
  // ready is never negated: the port has no wait states to insert

  always_ff @(posedge clk) begin
    if (anyRst) begin
      busy      <= 1'b1;
      standby   <= 1'b0;
      cmdAccept <= 1'b0;
      pinFunc   <= atapp_pkg::ATAPP_FN_PROTECT;
      iordy     <= 1'b1;
      iocs16N   <= 1'b1;
    end else begin
      busy      <= (state_r == INIT) || (state_r == EXEC);
      standby   <= (state_r == SLEEP);
      cmdAccept <= take;
      pinFunc   <= nvFunc;
      iordy     <= 1'b1;
      iocs16N   <= !(udmaRdActive || udmaWrActive || state_r == EXEC);
    end
  end

  always_ff @(posedge clk) begin
    if (anyRst) begin
      intrq <= 1'b0;
    end else if (state_r == DONE) begin
      intrq <= 1'b1;
    end else if (intAck) begin
      intrq <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ultra dma paths

  atapp_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_wrFifo (
    .clk      (clk),
    .srst     (anyRst),
    .inValid  (hostWordValid && udmaWrActive),
    .inReady  (fifoInReady),
    .inData   (hostWord),
    .outValid (mediaWordValid),
    .outReady (mediaReady),
    .outData  (mediaWord)
  );

  // negate readiness when the buffer fills; host may still send a word or two
  always_ff @(posedge clk) begin
    if (anyRst) begin
      ddmardyN_r <= 1'b1;
    end else begin
      ddmardyN_r <= !(udmaWrActive && fifoInReady);
    end
  end
  assign ddmardyN = ddmardyN_r;

  assign rdTake      = udmaRdActive && !hdmardyN && rdWordValid;
  assign rdWordReady = rdTake;

  always_ff @(posedge clk) begin
    if (anyRst) begin
      dstrobe_r <= 1'b1;
      dataOut_r <= '0;
    end else if (rdTake) begin
      dataOut_r <= rdWord;
      dstrobe_r <= !dstrobe_r;
    end
  end  // no word or host paused: strobe holds still
  assign dstrobe = dstrobe_r;
  assign dataOut = dataOut_r;

endmodule // atapp_port

// ---- hdl/atapp_pkg.sv ----
// Purpose: shared constants and carriers for the protect/power-down host port
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   command opcodes follow common ATA practice; the pin-function opcode is a parameter
package atapp_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  localparam int unsigned INIT_BUSY_SEC = 5;
  localparam int unsigned INIT_BUSY_CYC = CLK_HZ * INIT_BUSY_SEC;
  localparam int unsigned CMD_EXEC_CYC  = 4;

  localparam logic [7:0] REFUSE_STATUS = 8'h51;
  localparam logic [7:0] REFUSE_ERROR  = 8'h04;
  localparam logic [7:0] OK_STATUS     = 8'h50;
  localparam logic [7:0] OK_ERROR      = 8'h00;
  localparam logic [7:0] BUSY_STATUS   = 8'h80;

  // destructive opcodes
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'hC0;
  localparam logic [7:0] CMD_FORMAT_TRACK = 8'h50;
  localparam logic [7:0] CMD_WRITE_DMA    = 8'hCA;
  localparam logic [7:0] CMD_WRITE_DMA_NR = 8'hCB;
  localparam logic [7:0] CMD_WRITE_LONG   = 8'h32;
  localparam logic [7:0] CMD_WRITE_LONG_N = 8'h33;
  localparam logic [7:0] CMD_WRITE_MULT   = 8'hC5;
  localparam logic [7:0] CMD_WRITE_MULT_E = 8'hCD;
  localparam logic [7:0] CMD_WRITE_SECT   = 8'h30;
  localparam logic [7:0] CMD_WRITE_SECT_N = 8'h31;
  localparam logic [7:0] CMD_WRITE_SECT_E = 8'h38;
  localparam logic [7:0] CMD_WRITE_VERIFY = 8'h3C;

  // pin-function select command and its argument (in the feature byte)
  localparam logic [7:0] CMD_PIN_FUNC     = 8'h8B;
  localparam logic [7:0] PIN_FUNC_PROTECT = 8'h00;
  localparam logic [7:0] PIN_FUNC_PWRDN   = 8'h01;

  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned WORD_W     = 16;

  typedef enum logic {
    ATAPP_FN_PROTECT,
    ATAPP_FN_PWRDN
  } atapp_func_t;

  // command as taken from the task file
  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] feature;
  } atapp_cmd_t;

  // completion report presented to the host
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] error;
  } atapp_rpt_t;

endpackage

// ---- hdl/atapp_fifo.sv ----
// Purpose: small synchronous FIFO in the data path
// Assumes: single clock, synchronous active-high reset
// Notes:   full and empty are exact; no write when full, no read when empty
module atapp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;
  logic             doWr;
  logic             doRd;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;

  always_ff @(posedge clk) begin
    if (doWr) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
    end else begin
      if (doWr) begin
        wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + 1'b1;
      end
      if (doRd) begin
        rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      count_r <= '0;
    end else if (doWr && !doRd) begin
      count_r <= count_r + 1'b1;
    end else if (doRd && !doWr) begin
      count_r <= count_r - 1'b1;
    end
  end

endmodule // atapp_fifo

// ---- test/atapp_port_checker.sv ----
// Purpose: concurrent checks on the protect/power-down host port
// Assumes: one clock domain; CMD_CYC handed on by the bind
// Notes:   the reset check watches resetN and porN itself, so it keeps its own disable
module atapp_port_checker #(
  parameter int unsigned CMD_CYC = atapp_pkg::CMD_EXEC_CYC
) (
  // clock and resets
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  resetN,
  input wire logic                  porN,
  // command and report
  input wire logic                  protect_powerdown_pinN,
  input wire logic                  cmdAccept,
  input wire logic                  rptValid,
  input wire atapp_pkg::atapp_rpt_t rpt,
  // status
  input wire logic                  busy,
  input wire logic                  standby,
  input wire logic                  pinFunc,
  input wire logic                  iordy,
  input wire logic                  intrq,
  // read burst
  input wire logic                  udmaRdActive,
  input wire logic                  hdmardyN,
  input wire logic                  rdWordValid,
  input wire logic                  dstrobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // accept is registered at take, the report five edges after take
  localparam int RPT_DLY = CMD_CYC + 1;
  logic anyRst;
  logic rdTake;
  assign anyRst = srst | ~resetN | ~porN;
  assign rdTake = udmaRdActive & ~hdmardyN & rdWordValid;
  default clocking cb @(posedge clk); endclocking
  default disable iff (anyRst);
  ////////////////////////////////////////////////////////////////////////////////
  property p_ready; iordy; endproperty
  a_ready: assert property (p_ready) else $error("ready line dropped");
  property p_rptTime; cmdAccept |-> ##RPT_DLY rptValid; endproperty
  a_rptTime: assert property (p_rptTime) else $error("report late or missing");
  property p_refuseCode;
    rptValid && rpt.status == atapp_pkg::REFUSE_STATUS |-> rpt.error == atapp_pkg::REFUSE_ERROR;
  endproperty
  a_refuseCode: assert property (p_refuseCode) else $error("refusal error code wrong");
  property p_intrq; rptValid |-> intrq; endproperty
  a_intrq: assert property (p_intrq) else $error("no interrupt with report");
  property p_standbyStay; standby |=> standby; endproperty
  a_standbyStay: assert property (p_standbyStay) else $error("standby left without reset");
  property p_noAccept; standby |-> !cmdAccept; endproperty
  a_noAccept: assert property (p_noAccept) else $error("command taken in standby");
  property p_pwrdnEnter;
    rptValid && pinFunc && !protect_powerdown_pinN |-> ##[1:2] standby;
  endproperty
  a_pwrdnEnter: assert property (p_pwrdnEnter) else $error("standby not entered");
  property p_strobe; $changed(dstrobe) |-> $past(rdTake); endproperty
  a_strobe: assert property (p_strobe) else $error("strobe edge without a word");
  property p_rstLevels;
    disable iff (srst) (!resetN || !porN) |=> busy && !intrq && !standby;
  endproperty
  a_rstLevels: assert property (p_rstLevels) else $error("reset levels wrong");
  // main scenarios reached
  c_refuse: cover property (rptValid && rpt.status == atapp_pkg::REFUSE_STATUS);
  c_standby: cover property ($rose(standby));
  c_strobe: cover property ($changed(dstrobe));
endmodule  // atapp_port_checker

// ---- test/atapp_host_model.sv ----
// Purpose: host-side partner: retained function cell and read-burst receiver
// Assumes: same clock as the port
// Notes:   the cell has no reset on purpose, it must outlive every reset
module atapp_host_model (
  // clock
  input  wire logic       clk,
  // retained cell
  input  wire logic       nvWrite,
  input  wire logic       nvWrData,
  input  wire logic       busy,
  output logic            nvFirstBoot,
  output logic            nvFunc,
  // read burst receiver
  input  wire logic       hostPause,
  input  wire logic       dstrobe,
  output logic            hdmardyN,
  output logic      [7:0] strobeEdges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busyQ;
  initial begin
    nvFirstBoot = 1'h1;
    nvFunc      = 1'h0;
    busyQ       = 1'h0;
    strobeEdges = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    busyQ <= busy;
    if (nvWrite) nvFunc <= nvWrData;
    if (busyQ && !busy) nvFirstBoot <= 1'h0;
  end
  // both strobe edges carry a word
  always @(dstrobe) strobeEdges = strobeEdges + 8'h01;
  assign hdmardyN = hostPause;
endmodule  // atapp_host_model

// ---- test/atapp_port_tb.sv ----
// Purpose: self-checking bench for the protect/power-down host port
// Assumes: init count cut to 20 cycles; outputs sampled on the falling edge
// Notes:   inputs change by non-blocking assignment on the rising edge
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned INIT = 20;
  localparam logic [15:0] OK  = {atapp_pkg::OK_STATUS, atapp_pkg::OK_ERROR};
  localparam logic [15:0] BAD = {atapp_pkg::REFUSE_STATUS, atapp_pkg::REFUSE_ERROR};
  localparam logic [7:0]  RD  = 8'h20;  // sector read, harmless under protect
  localparam logic [7:0]  DESTR [12] = '{
    atapp_pkg::CMD_ERASE_SECTOR, atapp_pkg::CMD_FORMAT_TRACK, atapp_pkg::CMD_WRITE_DMA,
    atapp_pkg::CMD_WRITE_DMA_NR, atapp_pkg::CMD_WRITE_LONG, atapp_pkg::CMD_WRITE_LONG_N,
    atapp_pkg::CMD_WRITE_MULT, atapp_pkg::CMD_WRITE_MULT_E, atapp_pkg::CMD_WRITE_SECT,
    atapp_pkg::CMD_WRITE_SECT_N, atapp_pkg::CMD_WRITE_SECT_E, atapp_pkg::CMD_WRITE_VERIFY};
  int bad_count = 0;
  int checked   = 0;
  int n;
  logic clk = 1'h0, srst = 1'h1, resetN = 1'h1, porN = 1'h1, pinN = 1'h1, intAck = 1'h0;
  logic cmdValid = 1'h0, cmdAccept, rptValid, busy, standby, pinFunc, iordy, iocs16N, intrq;
  atapp_pkg::atapp_cmd_t cmdIn = '0;
  atapp_pkg::atapp_rpt_t rpt;
  logic udmaWrActive = 1'h0, hostWordValid = 1'h0, mediaReady = 1'h0, ddmardyN, mediaWordValid;
  logic udmaRdActive = 1'h0, rdWordValid = 1'h0, hostPause = 1'h0, hdmardyN, rdWordReady, dstrobe;
  logic [15:0] hostWord = '0, rdWord = '0, mediaWord, dataOut;
  logic nvFirstBoot, nvFunc, nvWrite, nvWrData;
  logic [7:0] edges;
  always #20 clk = ~clk;
  atapp_port #(.INIT_CYC(INIT)) dut (
    .clk, .srst, .resetN, .porN, .protect_powerdown_pinN(pinN), .cmdValid, .cmdIn, .cmdAccept,
    .rpt, .rptValid, .busy, .standby, .pinFunc, .iordy, .iocs16N, .intrq, .intAck,
    .udmaWrActive, .hostWordValid, .hostWord, .ddmardyN, .mediaWordValid, .mediaWord,
    .mediaReady, .udmaRdActive, .hdmardyN, .rdWordValid, .rdWord, .rdWordReady, .dstrobe,
    .dataOut, .nvFirstBoot, .nvFunc, .nvWrite, .nvWrData);
  atapp_host_model partner (.clk, .nvWrite, .nvWrData, .busy, .nvFirstBoot, .nvFunc,
    .hostPause, .dstrobe, .hdmardyN, .strobeEdges(edges));
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task report_and_stop();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wait_idle();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (busy !== 1'h0 && n < 200);
  endtask
  task hw_reset(input bit por);
    @(posedge clk) begin
      porN   <= ~por;
      resetN <= por;
    end
    repeat (2) @(posedge clk);
    porN   <= 1'h1;
    resetN <= 1'h1;
    wait_idle();
  endtask
  // holds the request until accept is seen; acc low expects it ignored
  task issue(input logic [7:0] op, input logic [7:0] ft, input logic acc, input logic [15:0] exp);
    n = 0;
    @(posedge clk) begin
      cmdValid <= 1'h1;
      cmdIn    <= {op, ft};
    end
    do begin
      @(negedge clk);
      n++;
    end while (cmdAccept !== 1'h1 && n < 12);
    @(posedge clk) cmdValid <= 1'h0;
    check(n < 12, acc);
    if (acc) begin
      n = 0;
      while (rptValid !== 1'h1 && n < 12) begin
        @(negedge clk);
        n++;
      end
      check(rpt, exp);
      check(intrq, 1'h1);
      @(posedge clk) intAck <= 1'h1;
      @(posedge clk) intAck <= 1'h0;
      @(negedge clk) check(intrq, 1'h0);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_init();
    repeat (5) @(posedge clk);
    srst <= 1'h0;
    wait_idle();
    check(n >= INIT && n <= INIT + 2, 1'h1);
    check({iordy, iocs16N, intrq}, 3'h6);
    hw_reset(1'h0);
    check(n <= 3, 1'h1);
    @(posedge clk) srst <= 1'h1;
    @(posedge clk) srst <= 1'h0;
    wait_idle();
    check({n <= 3, busy, intrq}, 3'h4);
  endtask
  task t_protect();
    @(posedge clk) pinN <= 1'h0;
    foreach (DESTR[i]) issue(DESTR[i], 8'h00, 1'h1, BAD);
    issue(RD, 8'h00, 1'h1, OK);
    @(posedge clk) pinN <= 1'h1;
    issue(atapp_pkg::CMD_WRITE_SECT, 8'h00, 1'h1, OK);
  endtask
  task t_pwrdn();
    issue(atapp_pkg::CMD_PIN_FUNC, atapp_pkg::PIN_FUNC_PWRDN, 1'h1, OK);
    repeat (3) @(negedge clk);
    check(pinFunc, 1'h1);
    hw_reset(1'h0);
    check(pinFunc, 1'h1);
    @(posedge clk) pinN <= 1'h0;
    issue(atapp_pkg::CMD_WRITE_SECT, 8'h00, 1'h1, OK);
    check(standby, 1'h1);
    issue(RD, 8'h00, 1'h0, OK);
    hw_reset(1'h0);
    check(standby, 1'h1);
    @(posedge clk) pinN <= 1'h1;
    hw_reset(1'h1);
    check({standby, pinFunc}, 2'h1);
    issue(atapp_pkg::CMD_PIN_FUNC, atapp_pkg::PIN_FUNC_PROTECT, 1'h1, OK);
    repeat (3) @(negedge clk);
    check(pinFunc, 1'h0);
  endtask
  task t_write();
    @(posedge clk) udmaWrActive <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk) begin
        hostWordValid <= 1'h1;
        hostWord      <= 16'hA000 + 16'(i);
      end
    end
    @(posedge clk) hostWordValid <= 1'h0;
    repeat (2) @(negedge clk);
    check(ddmardyN, 1'h1);
    check(iocs16N, 1'h0);
    @(posedge clk) mediaReady <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      check(mediaWord, 16'hA000 + 16'(i));
    end
    @(posedge clk) mediaReady <= 1'h0;
    @(negedge clk);
    check({mediaWordValid, ddmardyN}, 2'h0);
  endtask
  task t_read();
    logic [7:0] e0;
    @(posedge clk) udmaRdActive <= 1'h1;
    e0 = edges;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) begin
        rdWordValid <= 1'h1;
        rdWord      <= 16'hB000 + 16'(i);
      end
    end
    @(posedge clk) begin
      hostPause <= 1'h1;
      rdWord    <= 16'hB004;
    end
    repeat (3) @(negedge clk);
    check({edges - e0, rdWordReady}, {8'h04, 1'h0});
    check(dataOut, 16'hB003);
    @(posedge clk) hostPause <= 1'h0;
    @(posedge clk) rdWordValid <= 1'h0;
    repeat (2) @(negedge clk);
    check({edges - e0, dataOut}, {8'h05, 16'hB004});
  endtask
  initial begin
    t_init();
    t_protect();
    t_pwrdn();
    t_write();
    t_read();
    report_and_stop();
  end
  // the run needs well under a thousand cycles
  initial begin
    #(40 * 4000);
    bad_count++;
    report_and_stop();
  end
endmodule  // testbench

bind atapp_port atapp_port_checker #(.CMD_CYC(CMD_CYC)) chk (.clk, .srst, .resetN, .porN,
  .protect_powerdown_pinN, .cmdAccept, .rptValid, .rpt, .busy, .standby, .pinFunc, .iordy,
  .intrq, .udmaRdActive, .hdmardyN, .rdWordValid, .dstrobe);
